//--- design/fsdp_pkg.sv
package fsdp_pkg;
	// ------------------------------------------------------------
	// geometry of the endpoints and the payload ram
	// ------------------------------------------------------------
	localparam int NUM_EP = 6;
	localparam int RAM_AW = 12;
	localparam int PTR_W = 10;
	localparam logic [5:0] DUAL_MASK = 6'h36; // endpoints one, two, four, five
	localparam logic [5:0] LARGE_MASK = 6'h30; // endpoints four and five
	localparam logic [PTR_W-1:0] EP_SMALL = 10'h040;
	localparam logic [PTR_W-1:0] EP_LARGE = 10'h200;
	localparam logic [RAM_AW-1:0] EP_BASE [NUM_EP] = '{12'h000, 12'h040, 12'h0c0,
		12'h140, 12'h180, 12'h580};

	// ------------------------------------------------------------
	// register offsets (byte addresses) and field positions
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_EPSEL = 5'h08;
	localparam logic [4:0] OFS_CSR = 5'h0c;
	localparam logic [4:0] OFS_FIFO = 5'h10;
	localparam int CTRL_PULLUP = 0;
	localparam int CTRL_XDIS = 1;
	localparam int CTRL_WAKEEN = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int STAT_SUSP = 0;
	localparam int STAT_RESUME = 1;
	localparam int STAT_WAKE = 2;
	localparam int STAT_SUSPENDED = 3;
	localparam int CSR_TXCOMP = 0;
	localparam int CSR_RXBK0 = 1;
	localparam int CSR_SETUP_RECEIVED_FLAG = 2;
	localparam int CSR_STALLSENT = 3;
	localparam int CSR_TXRDY = 4;
	localparam int CSR_FSTALL = 5;
	localparam int CSR_RXBK1 = 6;
	localparam int CSR_DIR = 7;
	localparam int CSR_TYPE = 8;
	localparam int CSR_EN = 10;
	localparam int CSR_CNT = 16;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int SUSPEND_US = 3000;
	localparam int RWAKE_US = 2000;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	localparam int RWAKE_CYC = RWAKE_US * CLK_MHZ;
	localparam int MON_CW = 20;

	typedef enum logic [1:0] {FSDP_CTL, FSDP_ISO, FSDP_BLK, FSDP_INT} fsdp_ep_type_t;
	typedef enum logic [1:0] {FSDP_TOK_OUT, FSDP_TOK_IN, FSDP_TOK_SETUP} fsdp_tok_t;
	typedef enum logic [1:0] {FSDP_HS_ACK, FSDP_HS_NAK, FSDP_HS_STALL} fsdp_hs_t;

	// payload size of one bank of an endpoint
	function automatic logic [PTR_W-1:0] fsdp_max(input logic [2:0] ep);
		return (ep < NUM_EP && LARGE_MASK[ep]) ? EP_LARGE : EP_SMALL;
	endfunction

	// ram address of a bank
	function automatic logic [RAM_AW-1:0] fsdp_base(input logic [2:0] ep, input logic bank);
		if (ep >= NUM_EP) begin
			return '0;
		end
		return EP_BASE[ep] + ((bank && DUAL_MASK[ep]) ? {2'h0, fsdp_max(ep)} : 12'h000);
	endfunction
endpackage

//--- design/fsdp_ram.sv
`timescale 1ns/100ps
// two independent ports; each read comes out of a register one cycle later
module fsdp_ram (
	input wire logic clk_sys_i,
	// processor side
	input wire logic [fsdp_pkg::RAM_AW-1:0] a_addr_i,
	input wire logic a_we_i,
	input wire logic [7:0] a_wd_i,
	output logic [7:0] a_q_o,
	// engine side
	input wire logic [fsdp_pkg::RAM_AW-1:0] b_addr_i,
	input wire logic b_we_i,
	input wire logic [7:0] b_wd_i,
	output logic [7:0] b_q_o
);
	import fsdp_pkg::*;

	logic [7:0] mem [2**RAM_AW];

	// both ports in one process: the array may have only one writing process
	always_ff @(posedge clk_sys_i) begin
		if (a_we_i) begin
			mem[a_addr_i] <= a_wd_i;
		end
		if (b_we_i) begin
			mem[b_addr_i] <= b_wd_i;
		end
		a_q_o <= mem[a_addr_i];
		b_q_o <= mem[b_addr_i];
	end
endmodule

//--- design/fsdp_linkmon.sv
`timescale 1ns/100ps
// watches the idle line for suspend, activity for resume, and drives remote wakeup
module fsdp_linkmon #(
	parameter int SUSP_CYC = fsdp_pkg::SUSPEND_CYC,
	parameter int WAKE_CYC = fsdp_pkg::RWAKE_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// line and wake
	input wire logic line_idle_i,
	input wire logic wake_i,
	input wire logic wake_en_i,
	// state and events
	output logic suspended_o,
	output logic suspend_ev_o,
	output logic resume_ev_o,
	output logic wake_ev_o,
	output logic drive_k_o
);
	import fsdp_pkg::*;

	typedef enum logic [1:0] {M_ACTIVE, M_SUSP, M_WAKE} fsdp_mon_st_t;

	fsdp_mon_st_t st_r, st_nxt;
	logic [MON_CW-1:0] cnt_r, cnt_nxt;
	logic susp_ev_nxt, res_ev_nxt, wake_ev_nxt, k_nxt;

	// next state of the monitor
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		susp_ev_nxt = 1'b0;
		res_ev_nxt = 1'b0;
		wake_ev_nxt = 1'b0;
		k_nxt = drive_k_o;
		case (st_r)
			M_ACTIVE: begin
				cnt_nxt = line_idle_i ? cnt_r + 1'b1 : '0;
				if (line_idle_i && cnt_r == MON_CW'(SUSP_CYC - 1)) begin
					st_nxt = M_SUSP;
					susp_ev_nxt = 1'b1;
					cnt_nxt = '0;
				end
			end
			M_SUSP: begin
				if (!line_idle_i) begin
					st_nxt = M_ACTIVE;
					res_ev_nxt = 1'b1;
				end else if (wake_i && wake_en_i) begin
					st_nxt = M_WAKE;
					wake_ev_nxt = 1'b1;
					k_nxt = 1'b1;
				end
			end
			M_WAKE: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == MON_CW'(WAKE_CYC - 1)) begin
					st_nxt = M_ACTIVE;
					res_ev_nxt = 1'b1;
					k_nxt = 1'b0;
					cnt_nxt = '0;
				end
			end
			default: begin
				st_nxt = M_ACTIVE;
			end
		endcase
	end

	// monitor registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= M_ACTIVE;
			cnt_r <= '0;
			suspended_o <= 1'b0;
			suspend_ev_o <= 1'b0;
			resume_ev_o <= 1'b0;
			wake_ev_o <= 1'b0;
			drive_k_o <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			suspended_o <= (st_nxt != M_ACTIVE);
			suspend_ev_o <= susp_ev_nxt;
			resume_ev_o <= res_ev_nxt;
			wake_ev_o <= wake_ev_nxt;
			drive_k_o <= k_nxt;
		end
	end
endmodule

//--- design/fsdp_core.sv
`timescale 1ns/100ps
module fsdp_core #(
	parameter int SUSP_CYC = fsdp_pkg::SUSPEND_CYC,
	parameter int WAKE_CYC = fsdp_pkg::RWAKE_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register bus
	input wire logic [4:0] av_address_i,
	input wire logic av_read_i,
	input wire logic av_write_i,
	input wire logic [31:0] av_writedata_i,
	input wire logic [3:0] av_byteenable_i,
	output logic [31:0] av_readdata_o,
	output logic av_waitrequest_o,
	// tokens and data from the host
	input wire logic tok_valid_i,
	input wire fsdp_pkg::fsdp_tok_t tok_pid_i,
	input wire logic [3:0] tok_ep_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_end_i,
	input wire logic rx_crc_ok_i,
	input wire logic host_ack_i,
	input wire logic host_timeout_i,
	// data and handshakes to the host
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	output logic tx_zlp_o,
	output logic tx_data1_o,
	output logic hs_valid_o,
	output fsdp_pkg::fsdp_hs_t hs_code_o,
	// line, wake and transceiver
	input wire logic line_idle_i,
	input wire logic ext_wake_i,
	output logic pullup_enable_o,
	output logic transceiver_disable_o,
	output logic resume_k_o,
	output logic irq_o
);
	import fsdp_pkg::*;

	typedef enum logic [2:0] {E_IDLE, E_RX, E_TXRD, E_TXLD, E_TXPUT, E_WAITHS} fsdp_eng_st_t;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [2:0] ctrl_r, ctrl_nxt;
	logic [2:0] stat_r, stat_nxt;
	logic [2:0] sel_r, sel_nxt;
	logic [PTR_W-1:0] cptr_r, cptr_nxt;
	logic [1:0] acc_r, acc_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [NUM_EP-1:0] txcomp_r, txcomp_nxt, setup_r, setup_nxt, ssent_r, ssent_nxt;
	logic [NUM_EP-1:0] fstall_r, fstall_nxt, en_r, en_nxt, cread_r, cread_nxt;
	logic [NUM_EP-1:0] tog_r, tog_nxt, cbank_r, cbank_nxt, sbank_r, sbank_nxt;
	logic [1:0] txf_r [NUM_EP];
	logic [1:0] txf_nxt [NUM_EP];
	logic [1:0] rxf_r [NUM_EP];
	logic [1:0] rxf_nxt [NUM_EP];
	logic [PTR_W-1:0] cnt_r [NUM_EP][2];
	logic [PTR_W-1:0] cnt_nxt [NUM_EP][2];
	fsdp_ep_type_t typ_r [NUM_EP];
	fsdp_ep_type_t typ_nxt [NUM_EP];
	fsdp_eng_st_t st_r, st_nxt;
	logic [2:0] eep_r, eep_nxt;
	logic [PTR_W-1:0] eptr_r, eptr_nxt, elen_r, elen_nxt;
	logic drop_r, drop_nxt, over_r, over_nxt, esetup_r, esetup_nxt, eauto_r, eauto_nxt;
	logic b7_r, b7_nxt;
	fsdp_hs_t ehs_r, ehs_nxt, hs_code_nxt;
	logic tx_valid_nxt, tx_last_nxt, tx_zlp_nxt, tx_data1_nxt, hs_valid_nxt, irq_nxt;
	logic [7:0] tx_data_nxt;

	// ------------------------------------------------------------
	// combinational helpers
	// ------------------------------------------------------------
	logic [31:0] wd;
	logic sel_ok, req;
	logic [2:0] si, te;
	logic te_ok, tdual, tiso, tctl, edual, eiso;
	logic [RAM_AW-1:0] ram_a_addr, ram_b_addr;
	logic ram_a_we, ram_b_we;
	logic [7:0] ram_a_q, ram_b_q;
	logic suspended, susp_ev, res_ev, wake_ev;

	assign wd = av_writedata_i & {{8{av_byteenable_i[3]}}, {8{av_byteenable_i[2]}},
		{8{av_byteenable_i[1]}}, {8{av_byteenable_i[0]}}};
	assign req = av_read_i | av_write_i;
	assign sel_ok = (sel_r < NUM_EP);
	assign si = sel_ok ? sel_r : 3'h0;
	assign te = (tok_ep_i < NUM_EP) ? tok_ep_i[2:0] : 3'h0;
	assign te_ok = (tok_ep_i < NUM_EP) && en_r[te];
	assign tdual = DUAL_MASK[te];
	assign tiso = (typ_r[te] == FSDP_ISO);
	assign tctl = (typ_r[te] == FSDP_CTL);
	assign edual = DUAL_MASK[eep_r];
	assign eiso = (typ_r[eep_r] == FSDP_ISO);
	// processor and engine address separate ports, one bank each
	assign ram_a_addr = fsdp_base(si, cbank_r[si]) + {2'h0, cptr_r};
	assign ram_b_addr = fsdp_base(eep_r, sbank_r[eep_r]) + {2'h0, eptr_r};
	assign ram_b_we = (st_r == E_RX) && rx_valid_i && !drop_r && (eptr_r < fsdp_max(eep_r));

	// ------------------------------------------------------------
	// bus slave, endpoint flags and transaction engine
	// ------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		stat_nxt = stat_r;
		sel_nxt = sel_r;
		cptr_nxt = cptr_r;
		acc_nxt = acc_r;
		wait_nxt = wait_r;
		rdata_nxt = rdata_r;
		txcomp_nxt = txcomp_r;
		setup_nxt = setup_r;
		ssent_nxt = ssent_r;
		fstall_nxt = fstall_r;
		en_nxt = en_r;
		cread_nxt = cread_r;
		tog_nxt = tog_r;
		cbank_nxt = cbank_r;
		sbank_nxt = sbank_r;
		txf_nxt = txf_r;
		rxf_nxt = rxf_r;
		cnt_nxt = cnt_r;
		typ_nxt = typ_r;
		st_nxt = st_r;
		eep_nxt = eep_r;
		eptr_nxt = eptr_r;
		elen_nxt = elen_r;
		drop_nxt = drop_r;
		over_nxt = over_r;
		esetup_nxt = esetup_r;
		eauto_nxt = eauto_r;
		b7_nxt = b7_r;
		ehs_nxt = ehs_r;
		hs_valid_nxt = 1'b0;
		hs_code_nxt = hs_code_o;
		tx_valid_nxt = tx_valid_o;
		tx_data_nxt = tx_data_o;
		tx_last_nxt = tx_last_o;
		tx_zlp_nxt = tx_zlp_o;
		tx_data1_nxt = tx_data1_o;
		ram_a_we = 1'b0;
		// two wait cycles, then one cycle with waitrequest low
		if (req) begin
			case (acc_r)
				2'h0: begin
					acc_nxt = 2'h1;
				end
				2'h1: begin
					acc_nxt = 2'h2;
					wait_nxt = 1'b0;
					case (av_address_i)
						OFS_CTRL: rdata_nxt = {29'h0, ctrl_r};
						OFS_STAT: rdata_nxt = {28'h0, suspended, stat_r};
						OFS_EPSEL: rdata_nxt = {29'h0, sel_r};
						OFS_CSR: rdata_nxt = sel_ok ? {6'h0, cnt_r[si][cbank_r[si]], 5'h0,
							en_r[si], typ_r[si], cread_r[si], rxf_r[si][1], fstall_r[si],
							txf_r[si][cbank_r[si]], ssent_r[si], setup_r[si], rxf_r[si][0],
							txcomp_r[si]} : 32'h0;
						OFS_FIFO: rdata_nxt = {24'h0, ram_a_q};
						default: rdata_nxt = 32'h0;
					endcase
				end
				default: begin
					acc_nxt = 2'h0;
					wait_nxt = 1'b1;
					if (av_read_i && av_address_i == OFS_FIFO && cptr_r < fsdp_max(si)) begin
						cptr_nxt = cptr_r + 1'b1;
					end
					if (av_write_i) begin
						case (av_address_i)
							OFS_CTRL: ctrl_nxt = wd[2:0];
							OFS_STAT: stat_nxt = stat_r & ~wd[2:0];
							OFS_EPSEL: begin
								sel_nxt = wd[2:0];
								cptr_nxt = '0;
							end
							OFS_FIFO: begin
								ram_a_we = sel_ok && av_byteenable_i[0];
								if (cptr_r < fsdp_max(si)) begin
									cptr_nxt = cptr_r + 1'b1;
								end
							end
							OFS_CSR: if (sel_ok) begin
								txcomp_nxt[si] = txcomp_r[si] & ~wd[CSR_TXCOMP];
								setup_nxt[si] = setup_r[si] & ~wd[CSR_SETUP_RECEIVED_FLAG];
								ssent_nxt[si] = ssent_r[si] & ~wd[CSR_STALLSENT];
								fstall_nxt[si] = wd[CSR_FSTALL];
								typ_nxt[si] = fsdp_ep_type_t'(wd[CSR_TYPE+:2]);
								en_nxt[si] = wd[CSR_EN] | (si == 3'h0);
								if (wd[CSR_RXBK0]) begin
									rxf_nxt[si][0] = 1'b0;
								end
								if (wd[CSR_RXBK1]) begin
									rxf_nxt[si][1] = 1'b0;
								end
								// releasing a bank hands the other one to the processor on dual-bank endpoints
								if (wd[CSR_RXBK0] | wd[CSR_RXBK1] | wd[CSR_SETUP_RECEIVED_FLAG]) begin
									cptr_nxt = '0;
									cbank_nxt[si] = cbank_r[si] ^ DUAL_MASK[si];
								end
								if (wd[CSR_TXRDY] && !txf_r[si][cbank_r[si]]) begin
									txf_nxt[si][cbank_r[si]] = 1'b1;
									cnt_nxt[si][cbank_r[si]] = cptr_r;
									cptr_nxt = '0;
									cbank_nxt[si] = cbank_r[si] ^ DUAL_MASK[si];
								end
							end
							default: begin
							end
						endcase
					end
				end
			endcase
		end
		// monitor events win over a clear in the same cycle
		stat_nxt = stat_nxt | {wake_ev, res_ev, susp_ev};
		// bus-facing engine; link strobes arrive framed at the bit rate
		case (st_r)
			E_IDLE: begin
				tx_valid_nxt = 1'b0;
				if (tok_valid_i && te_ok) begin
					eep_nxt = te;
					eptr_nxt = '0;
					over_nxt = 1'b0;
					drop_nxt = 1'b0;
					esetup_nxt = 1'b0;
					eauto_nxt = 1'b0;
					case (tok_pid_i)
						FSDP_TOK_SETUP: if (tctl) begin
							st_nxt = E_RX; // always taken, into the bank that sbank_r points at
							esetup_nxt = 1'b1;
						end
						FSDP_TOK_OUT: begin
							st_nxt = E_RX;
							if (fstall_r[te]) begin
								drop_nxt = 1'b1;
								ehs_nxt = FSDP_HS_STALL;
							end else if (rxf_r[te][sbank_r[te]] || (setup_r[te] && !tdual)) begin
								drop_nxt = 1'b1;
								ehs_nxt = FSDP_HS_NAK;
							end
						end
						FSDP_TOK_IN: begin
							tx_data1_nxt = tog_r[te] & ~tiso;
							if (fstall_r[te]) begin
								hs_valid_nxt = 1'b1;
								hs_code_nxt = FSDP_HS_STALL;
								ssent_nxt[te] = 1'b1;
							end else if (txf_r[te][sbank_r[te]]) begin
								elen_nxt = cnt_r[te][sbank_r[te]];
								if (cnt_r[te][sbank_r[te]] == '0) begin
									st_nxt = E_TXPUT;
									tx_valid_nxt = 1'b1;
									tx_zlp_nxt = 1'b1;
									tx_last_nxt = 1'b1;
								end else begin
									st_nxt = E_TXRD;
								end
							end else if (tctl && !cread_r[te] && !setup_r[te]) begin
								st_nxt = E_TXPUT; // status IN after write or no-data
								eauto_nxt = 1'b1;
								tx_valid_nxt = 1'b1;
								tx_zlp_nxt = 1'b1;
								tx_last_nxt = 1'b1;
								tx_data1_nxt = 1'b1;
							end else if (tiso) begin
								st_nxt = E_TXPUT; // nothing loaded: empty frame
								eauto_nxt = 1'b1;
								tx_valid_nxt = 1'b1;
								tx_zlp_nxt = 1'b1;
								tx_last_nxt = 1'b1;
							end else begin
								hs_valid_nxt = 1'b1;
								hs_code_nxt = FSDP_HS_NAK;
							end
						end
						default: begin
						end
					endcase
				end
			end
			E_RX: begin
				if (rx_valid_i) begin
					if (eptr_r == '0) begin
						b7_nxt = rx_data_i[7];
					end
					if (eptr_r < fsdp_max(eep_r)) begin
						eptr_nxt = eptr_r + 1'b1;
					end else begin
						over_nxt = 1'b1;
					end
				end
				if (rx_end_i) begin
					st_nxt = E_IDLE;
					if (!rx_crc_ok_i || over_r) begin
						hs_valid_nxt = 1'b0; // silent: host retries, iso data lost
					end else if (drop_r) begin
						hs_valid_nxt = !eiso;
						hs_code_nxt = ehs_r;
						ssent_nxt[eep_r] = ssent_r[eep_r] | (ehs_r == FSDP_HS_STALL);
					end else begin
						cnt_nxt[eep_r][sbank_r[eep_r]] = eptr_r;
						hs_valid_nxt = !eiso;
						hs_code_nxt = FSDP_HS_ACK;
						if (esetup_r) begin
							setup_nxt[eep_r] = 1'b1;
							cread_nxt[eep_r] = b7_r; // direction decides status stage
							tog_nxt[eep_r] = 1'b1;
							fstall_nxt[eep_r] = 1'b0;
						end else begin
							// zero-length OUT in a read is flagged like any other OUT
							rxf_nxt[eep_r][sbank_r[eep_r]] = 1'b1;
							sbank_nxt[eep_r] = sbank_r[eep_r] ^ edual;
						end
					end
				end
			end
			E_TXRD: begin
				st_nxt = E_TXLD;
			end
			E_TXLD: begin
				st_nxt = E_TXPUT;
				tx_valid_nxt = 1'b1;
				tx_data_nxt = ram_b_q;
				tx_zlp_nxt = 1'b0;
				tx_last_nxt = (eptr_r + 1'b1 == elen_r);
			end
			E_TXPUT: begin
				if (tx_ready_i) begin
					tx_valid_nxt = 1'b0;
					eptr_nxt = eptr_r + 1'b1;
					st_nxt = tx_last_o ? E_WAITHS : E_TXRD;
					if (tx_last_o && eiso) begin
						st_nxt = E_IDLE; // no handshake, never resent
						txcomp_nxt[eep_r] = !eauto_r;
						txf_nxt[eep_r][sbank_r[eep_r]] = 1'b0;
						sbank_nxt[eep_r] = sbank_r[eep_r] ^ (edual & ~eauto_r);
					end
				end
			end
			E_WAITHS: begin
				if (host_ack_i) begin
					st_nxt = E_IDLE;
					txcomp_nxt[eep_r] = 1'b1;
					tog_nxt[eep_r] = ~tog_r[eep_r];
					if (!eauto_r) begin
						txf_nxt[eep_r][sbank_r[eep_r]] = 1'b0;
						sbank_nxt[eep_r] = sbank_r[eep_r] ^ edual;
					end
				end else if (host_timeout_i) begin
					st_nxt = E_IDLE; // bank kept for the host's retry
				end
			end
			default: begin
				st_nxt = E_IDLE;
			end
		endcase
		// one line covers port events and the txcomp, rxf, setup and ssent flags of every endpoint
		irq_nxt = |stat_nxt | |txcomp_nxt | |setup_nxt | |ssent_nxt;
		for (int i = 0; i < NUM_EP; i++) begin
			irq_nxt = irq_nxt | |rxf_nxt[i];
		end
	end

	// register everything
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= CTRL_RST;
			stat_r <= '0;
			sel_r <= '0;
			cptr_r <= '0;
			acc_r <= '0;
			wait_r <= 1'b1;
			rdata_r <= '0;
			txcomp_r <= '0;
			setup_r <= '0;
			ssent_r <= '0;
			fstall_r <= '0;
			en_r <= 6'h01;
			cread_r <= '0;
			tog_r <= '0;
			cbank_r <= '0;
			sbank_r <= '0;
			for (int i = 0; i < NUM_EP; i++) begin
				txf_r[i] <= '0;
				rxf_r[i] <= '0;
				cnt_r[i][0] <= '0;
				cnt_r[i][1] <= '0;
				typ_r[i] <= FSDP_CTL;
			end
			st_r <= E_IDLE;
			eep_r <= '0;
			eptr_r <= '0;
			elen_r <= '0;
			drop_r <= 1'b0;
			over_r <= 1'b0;
			esetup_r <= 1'b0;
			eauto_r <= 1'b0;
			b7_r <= 1'b0;
			ehs_r <= FSDP_HS_ACK;
			hs_valid_o <= 1'b0;
			hs_code_o <= FSDP_HS_ACK;
			tx_valid_o <= 1'b0;
			tx_data_o <= '0;
			tx_last_o <= 1'b0;
			tx_zlp_o <= 1'b0;
			tx_data1_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			stat_r <= stat_nxt;
			sel_r <= sel_nxt;
			cptr_r <= cptr_nxt;
			acc_r <= acc_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			txcomp_r <= txcomp_nxt;
			setup_r <= setup_nxt;
			ssent_r <= ssent_nxt;
			fstall_r <= fstall_nxt;
			en_r <= en_nxt;
			cread_r <= cread_nxt;
			tog_r <= tog_nxt;
			cbank_r <= cbank_nxt;
			sbank_r <= sbank_nxt;
			txf_r <= txf_nxt;
			rxf_r <= rxf_nxt;
			cnt_r <= cnt_nxt;
			typ_r <= typ_nxt;
			st_r <= st_nxt;
			eep_r <= eep_nxt;
			eptr_r <= eptr_nxt;
			elen_r <= elen_nxt;
			drop_r <= drop_nxt;
			over_r <= over_nxt;
			esetup_r <= esetup_nxt;
			eauto_r <= eauto_nxt;
			b7_r <= b7_nxt;
			ehs_r <= ehs_nxt;
			hs_valid_o <= hs_valid_nxt;
			hs_code_o <= hs_code_nxt;
			tx_valid_o <= tx_valid_nxt;
			tx_data_o <= tx_data_nxt;
			tx_last_o <= tx_last_nxt;
			tx_zlp_o <= tx_zlp_nxt;
			tx_data1_o <= tx_data1_nxt;
			irq_o <= irq_nxt;
		end
	end

	// transceiver control comes straight from the control register
	assign pullup_enable_o = ctrl_r[CTRL_PULLUP];
	assign transceiver_disable_o = ctrl_r[CTRL_XDIS];
	assign av_readdata_o = rdata_r;
	assign av_waitrequest_o = wait_r;

	// ------------------------------------------------------------
	// payload ram and line monitor
	// ------------------------------------------------------------
	fsdp_ram u_ram (
		.clk_sys_i(clk_sys_i),
		.a_addr_i(ram_a_addr),
		.a_we_i(ram_a_we),
		.a_wd_i(wd[7:0]),
		.a_q_o(ram_a_q),
		.b_addr_i(ram_b_addr),
		.b_we_i(ram_b_we),
		.b_wd_i(rx_data_i),
		.b_q_o(ram_b_q)
	);

	fsdp_linkmon #(
		.SUSP_CYC(SUSP_CYC),
		.WAKE_CYC(WAKE_CYC)
	) u_mon (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.line_idle_i(line_idle_i),
		.wake_i(ext_wake_i),
		.wake_en_i(ctrl_r[CTRL_WAKEEN]),
		.suspended_o(suspended),
		.suspend_ev_o(susp_ev),
		.resume_ev_o(res_ev),
		.wake_ev_o(wake_ev),
		.drive_k_o(resume_k_o)
	);
endmodule

//--- dv/fsdp_host_model.sv
`timescale 1ns/100ps
// host side: sends tokens and data packets, takes bytes and acks the last one
module fsdp_host_model (
	// clock
	input wire logic clk_sys_i,
	// from the port
	input wire logic tx_valid_o,
	input wire logic tx_last_o,
	// to the port
	output logic tok_valid_i,
	output fsdp_pkg::fsdp_tok_t tok_pid_i,
	output logic [3:0] tok_ep_i,
	output logic rx_valid_i,
	output logic [7:0] rx_data_i,
	output logic rx_end_i,
	output logic rx_crc_ok_i,
	output logic host_ack_i,
	output logic tx_ready_i
);
	import fsdp_pkg::*;
	initial begin
		{tok_valid_i, tok_ep_i, rx_valid_i, rx_data_i, rx_end_i, rx_crc_ok_i} = '0;
		{host_ack_i, tx_ready_i} = '0;
		tok_pid_i = FSDP_TOK_OUT;
	end
	// slow sink: ready every other cycle; ack the last byte taken
	always @(posedge clk_sys_i) begin
		tx_ready_i <= ~tx_ready_i;
		host_ack_i <= tx_valid_o && tx_ready_i && tx_last_o;
	end
	task tok(input fsdp_tok_t p, input logic [3:0] e);
		@(posedge clk_sys_i);
		tok_valid_i <= 1'b1;
		tok_pid_i <= p;
		tok_ep_i <= e;
		@(posedge clk_sys_i);
		tok_valid_i <= 1'b0;
	endtask
	// n bytes counting up from 0x10, then end with the crc verdict
	task pkt(input int n, input logic ok);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys_i);
			rx_valid_i <= 1'b1;
			rx_data_i <= 8'h10 + 8'(i);
		end
		@(posedge clk_sys_i);
		rx_valid_i <= 1'b0;
		rx_data_i <= ~rx_data_i;
		rx_end_i <= 1'b1;
		rx_crc_ok_i <= ok;
		@(posedge clk_sys_i);
		rx_end_i <= 1'b0;
	endtask
endmodule

//--- dv/fsdp_core_chk.sv
`timescale 1ns/100ps
// watches bus answer timing, handshakes and status packets
module fsdp_core_chk (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register bus
	input wire logic av_read_i,
	input wire logic av_write_i,
	input wire logic av_waitrequest_o,
	// link
	input wire logic tok_valid_i,
	input wire fsdp_pkg::fsdp_tok_t tok_pid_i,
	input wire logic [3:0] tok_ep_i,
	input wire logic rx_end_i,
	input wire logic rx_crc_ok_i,
	input wire logic tx_ready_i,
	input wire logic tx_valid_o,
	input wire logic tx_zlp_o,
	input wire logic tx_data1_o,
	input wire logic hs_valid_o,
	input wire fsdp_pkg::fsdp_hs_t hs_code_o,
	input wire logic irq_o
);
	import fsdp_pkg::*;
	logic [1:0] tk_r;
	logic [1:0] tk_nxt;
	// last token: [1] was a setup, [0] went to endpoint zero
	always_comb begin
		tk_nxt = tok_valid_i ? {tok_pid_i == FSDP_TOK_SETUP, tok_ep_i == 4'h0} : tk_r;
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tk_r <= 2'h0;
		end else begin
			tk_r <= tk_nxt;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wait;
		av_waitrequest_o [*2] ##1 !av_waitrequest_o;
	endsequence
	sequence s_setup_end;
		rx_end_i && rx_crc_ok_i && tk_r[1];
	endsequence
	a_wait_two: assert property ($rose(av_read_i || av_write_i) |-> s_wait)
		else $error("bus answer late or early");
	a_wait_one: assert property (!av_waitrequest_o |=> av_waitrequest_o)
		else $error("answer longer than one cycle");
	a_hs_pulse: assert property (hs_valid_o |=> !hs_valid_o)
		else $error("handshake longer than one cycle");
	a_setup_ack: assert property (s_setup_end |=> hs_valid_o && hs_code_o == FSDP_HS_ACK)
		else $error("setup not acked");
	a_setup_irq: assert property (s_setup_end |-> ##[1:3] irq_o)
		else $error("no interrupt after setup");
	a_bad_crc: assert property (rx_end_i && !rx_crc_ok_i |=> !hs_valid_o)
		else $error("handshake on bad packet");
	a_zlp_data1: assert property (tx_valid_o && tx_zlp_o && tk_r[0] |-> tx_data1_o)
		else $error("status packet not data1");
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o)
		else $error("tx byte dropped");
endmodule
bind fsdp_core fsdp_core_chk i_fsdp_core_chk (.clk_sys_i, .rst_n_i, .av_read_i, .av_write_i,
	.av_waitrequest_o, .tok_valid_i, .tok_pid_i, .tok_ep_i, .rx_end_i, .rx_crc_ok_i, .tx_ready_i,
	.tx_valid_o, .tx_zlp_o, .tx_data1_o, .hs_valid_o, .hs_code_o, .irq_o);

//--- dv/tb_fsdp_core.sv
`timescale 1ns/100ps
module tb_fsdp_core;
	import fsdp_pkg::*;
	logic clk_sys_i, rst_n_i, av_read_i, av_write_i, av_waitrequest_o, tx_valid_o, tx_last_o;
	logic tx_zlp_o, tx_data1_o, hs_valid_o, line_idle_i, pullup_enable_o, transceiver_disable_o;
	logic resume_k_o, irq_o, tok_valid_i, rx_valid_i, rx_end_i, rx_crc_ok_i, host_ack_i, tx_ready_i;
	logic [4:0] av_address_i;
	logic [31:0] av_writedata_i, av_readdata_o, q;
	logic [3:0] tok_ep_i;
	logic [7:0] rx_data_i, tx_data_o;
	fsdp_tok_t tok_pid_i;
	fsdp_hs_t hs_code_o;
	wire logic [3:0] av_byteenable_i = 4'hf;
	wire logic host_timeout_i = 1'b0;
	wire logic ext_wake_i = 1'b0;
	int num_errors, compares;
	fsdp_core #(.SUSP_CYC(20), .WAKE_CYC(10)) i_fsdp_core (.*);
	fsdp_host_model i_fsdp_host_model (.*);
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		av_address_i <= a;
		av_write_i <= w;
		av_read_i <= !w;
		av_writedata_i <= d;
		@(posedge clk_sys_i);
		while (av_waitrequest_o !== 1'b0) begin
			@(posedge clk_sys_i);
		end
		q = av_readdata_o;
		av_write_i <= 1'b0;
		av_read_i <= 1'b0;
	endtask
	task hs(input logic [1:0] c);
		for (int n = 0; n < 40 && hs_valid_o !== 1'b1; n++) begin
			@(negedge clk_sys_i);
		end
		chk({hs_valid_o, hs_code_o}, {1'b1, c});
	endtask
	task t_regs();
		bus(1, OFS_CTRL, 32'h3);
		@(negedge clk_sys_i);
		chk({transceiver_disable_o, pullup_enable_o}, 2'h3);
		bus(0, 5'h14, 32'h0);
		chk(q, 32'h0);
		bus(1, OFS_CTRL, 32'h2);
		@(negedge clk_sys_i);
		chk({transceiver_disable_o, pullup_enable_o}, 2'h2);
	endtask
	task t_setup();
		i_fsdp_host_model.tok(FSDP_TOK_SETUP, 4'h0);
		i_fsdp_host_model.pkt(8, 1'b1);
		hs(FSDP_HS_ACK);
		bus(0, OFS_CSR, 32'h0);
		chk(q, 32'h0008_0404);
		for (int i = 0; i < 8; i++) begin
			bus(0, OFS_FIFO, 32'h0);
			chk(q, 32'h10 + i);
		end
		bus(1, OFS_CSR, 32'h404);
		@(negedge clk_sys_i);
		chk(irq_o, 1'b0);
	endtask
	task t_status();
		i_fsdp_host_model.tok(FSDP_TOK_IN, 4'h0);
		for (int n = 0; n < 40 && tx_valid_o !== 1'b1; n++) begin
			@(negedge clk_sys_i);
		end
		chk({tx_valid_o, tx_zlp_o, tx_data1_o}, 3'h7);
		while (tx_valid_o !== 1'b0) begin
			@(negedge clk_sys_i);
		end
		bus(0, OFS_CSR, 32'h0);
		chk(q & 32'hffff, 32'h401);
		bus(1, OFS_CSR, 32'h401);
	endtask
	task t_nak();
		i_fsdp_host_model.tok(FSDP_TOK_OUT, 4'h0);
		i_fsdp_host_model.pkt(2, 1'b1);
		hs(FSDP_HS_ACK);
		i_fsdp_host_model.tok(FSDP_TOK_OUT, 4'h0);
		i_fsdp_host_model.pkt(1, 1'b1);
		hs(FSDP_HS_NAK);
		bus(1, OFS_CSR, 32'h402);
		i_fsdp_host_model.tok(FSDP_TOK_OUT, 4'h0);
		i_fsdp_host_model.pkt(3, 1'b0);
		i_fsdp_host_model.tok(FSDP_TOK_OUT, 4'h0);
		i_fsdp_host_model.pkt(0, 1'b1);
		hs(FSDP_HS_ACK);
		bus(1, OFS_CSR, 32'h402);
	endtask
	task t_stall();
		bus(1, OFS_CSR, 32'h420);
		i_fsdp_host_model.tok(FSDP_TOK_IN, 4'h0);
		hs(FSDP_HS_STALL);
		bus(0, OFS_CSR, 32'h0);
		chk(q & 32'h28, 32'h28);
		bus(1, OFS_CSR, 32'h408);
	endtask
	task t_iso();
		bus(1, OFS_EPSEL, 32'h1);
		bus(1, OFS_CSR, 32'h500);
		i_fsdp_host_model.tok(FSDP_TOK_IN, 4'h1);
		@(negedge clk_sys_i);
		chk({tx_valid_o, tx_zlp_o, tx_data1_o, hs_valid_o}, 4'hc);
	endtask
	task t_susp();
		@(posedge clk_sys_i);
		line_idle_i <= 1'b1;
		repeat (30) @(posedge clk_sys_i);
		bus(0, OFS_STAT, 32'h0);
		chk(q & 32'hf, 32'h9);
		line_idle_i <= 1'b0;
		bus(0, OFS_STAT, 32'h0);
		chk({q[3:0] & 4'ha, irq_o}, {4'h2, 1'b1});
	endtask
	task end_sim();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// free-running clock
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// watchdog
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		num_errors++;
		end_sim();
	end
	// reset, then the scenarios
	initial begin
		{rst_n_i, av_read_i, av_write_i, line_idle_i, av_address_i, av_writedata_i} = '0;
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_regs();
		t_setup();
		t_status();
		t_nak();
		t_stall();
		t_iso();
		t_susp();
		end_sim();
	end
endmodule
